// ==== e1_overhead_receive_insert_test.sv ====
// e1_overhead_receive_insert_test.sv: self-checking bench for the overhead insertion block
// assumes e1oh_top and the framer model; output bits are judged against the bits the model sent
`timescale 1ns/1ps
`default_nettype none
`include "e1oh_cfg.svh"

module e1_overhead_receive_insert_test;
  localparam logic [7:0] buf_a = 8'h6F;
  localparam logic [7:0] buf_b = 8'h07;
  localparam int         nb    = 8800;
  logic       clk_sys;
  logic       reset_n;
  logic [7:0] mpu_addr;
  logic [7:0] mpu_wdata;
  logic       mpu_wr;
  logic       mpu_rd;
  logic [7:0] mpu_rdata;
  logic       pcm_link_clk;
  logic       hdsl_rx_data;
  logic       receive_multiframe_sync_in;
  logic       pcm_tx_data;
  logic       locked;
  logic       code_det;
  logic       ovf;
  logic       go;
  int         bit_no;
  int         lag;
  int         n_errors;
  int         checked;
  logic       sent [nb];
  logic       got  [nb];

  e1oh_top dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .mpu_addr(mpu_addr), .mpu_wdata(mpu_wdata),
    .mpu_wr(mpu_wr), .mpu_rd(mpu_rd), .mpu_rdata(mpu_rdata), .pcm_link_clk(pcm_link_clk),
    .hdsl_rx_data(hdsl_rx_data), .receive_multiframe_sync_in(receive_multiframe_sync_in),
    .pcm_tx_data(pcm_tx_data), .multiframe_locked(locked), .inband_code_detect(code_det), .stream_overflow(ovf)
  );

  e1oh_framer_model frm (
    .clk_sys(clk_sys), .go(go), .pcm_link_clk(pcm_link_clk), .hdsl_rx_data(hdsl_rx_data),
    .receive_multiframe_sync_in(receive_multiframe_sync_in), .bit_no(bit_no)
  );

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    mpu_addr = a;
    mpu_wdata = d;
    mpu_wr = 1'b1;
    @(negedge clk_sys);
    mpu_wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    mpu_addr = a;
    mpu_rd = 1'b1;
    @(negedge clk_sys);
    mpu_rd = 1'b0;
    @(negedge clk_sys);
    d = mpu_rdata;
  endtask : reg_rd

  // bounded wait on the link bit count; running out ends the run
  task automatic wait_bit(input int target);
    int i;
    for (i = 0; i < 40000 && bit_no < target; i++) @(negedge clk_sys);
    if (bit_no < target) begin
      n_errors++;
      $display("CHECK FAILED link progress expected %0d seen %0d", target, bit_no);
      summarize();
    end
  endtask : wait_bit

  function automatic logic exp_bit(input int j, input logic all_ones_slot_override);
    int f;
    int s;
    logic e;
    f = (j >> 8) % 16;
    s = (j >> 3) % 32;
    e = sent[j];
    if (s != 0) return all_ones_slot_override ? 1'b1 : e;
    if (f % 2 == 0) return (all_ones_slot_override && j % 8 == 0) ? 1'b1 : e;
    case (j % 8)
      0: return (f == 13) ? buf_a[0] : (f == 15) ? buf_a[1] : e;
      2: return buf_a[2];
      3: return buf_b[0];
      4: return buf_a[3];
      5: return buf_a[4 + (f / 2) % 4];
      7: return buf_b[2];
      default: return e;
    endcase
  endfunction : exp_bit

  task automatic check_span(input int first, input int last, input logic all_ones_slot_override);
    int j;
    for (j = first; j < last; j++) check("stream bit", {7'h00, exp_bit(j, all_ones_slot_override)}, {7'h00, got[j + lag]});
  endtask : check_span

  // sa7 mode left 0 while its buffer bit is 1, so the buffer must be ignored there
  task automatic test_regs();
    logic [7:0] d;
    logic [7:0] ad [4];
    logic [7:0] va [4];
    int k;
    ad = '{`E1OH_OFS_CTRL_A, `E1OH_OFS_CTRL_B, `E1OH_OFS_BUF_B, `E1OH_OFS_BUF_A};
    va = '{8'h67, 8'h13, buf_b, buf_a};
    for (k = 0; k < 4; k++) begin
      reg_rd(ad[k], d);
      check("reset value", 8'h00, d);
      reg_wr(ad[k], va[k]);
      reg_rd(ad[k], d);
      check("readback", va[k], d);
    end
    reg_wr(8'hB3, 8'hFF);
    reg_rd(8'hB3, d);
    check("unmapped read", 8'h00, d);
    $display("test_regs done");
  endtask : test_regs

  // first multiframe must pass untouched although settings were written during it
  task automatic test_pass();
    int l;
    int j;
    int ok;
    lag = 0;
    for (l = 1; l < 9 && lag == 0; l++) begin
      ok = 1;
      for (j = 64; j < 4000; j++) if (got[j + l] !== sent[j]) ok = 0;
      if (ok == 1) lag = l;
    end
    check("passthrough found", 8'h01, {7'h00, lag != 0});
    $display("test_pass done, lag %0d", lag);
  endtask : test_pass

  task automatic test_insert();
    check_span(4096, 8192, 1'b0);
    $display("test_insert done");
  endtask : test_insert

  task automatic test_alarm();
    check_span(8192, 8704, 1'b1);
    $display("test_alarm done");
  endtask : test_alarm

  // sync enabled out of reset: the alignment word in frames 1..11 must bring lock
  task automatic test_lock();
    logic [7:0] d;
    wait_bit(3200);
    reg_rd(`E1OH_OFS_MON0, d);
    check("status locked", 8'h80, d);
    check("locked pin", 8'h01, {7'h00, locked});
    $display("test_lock done");
  endtask : test_lock

  // e-bits arrive as 0 in frames 13 and 15, counted once processing is on
  task automatic test_ecount();
    logic [7:0] d;
    wait_bit(8100);
    reg_rd(`E1OH_OFS_E_CNT, d);
    check("e count", 8'h02, d);
    $display("test_ecount done");
  endtask : test_ecount

  // two multiframes are too few for a code; sync disabled drops lock
  task automatic test_flags();
    logic [7:0] d;
    reg_rd(`E1OH_OFS_E_CNT, d);
    check("e count cleared", 8'h00, d);
    check("locked pin", 8'h00, {7'h00, locked});
    check("code detect", 8'h00, {7'h00, code_det});
    check("overflow", 8'h00, {7'h00, ovf});
    $display("test_flags done");
  endtask : test_flags

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge pcm_link_clk) begin
    if (bit_no < nb) begin
      sent[bit_no] = hdsl_rx_data;
      got[bit_no] = pcm_tx_data;
    end
  end

  initial begin
    reset_n = 1'b0;
    mpu_addr = 8'h00;
    mpu_wdata = 8'h00;
    mpu_wr = 1'b0;
    mpu_rd = 1'b0;
    go = 1'b0;
    lag = 0;
    n_errors = 0;
    checked = 0;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    go = 1'b1;
    test_regs();
    test_lock();
    wait_bit(4400);
    test_pass();
    // alarm raised together with the e counter clear, in mid multiframe; c bits forced to ones
    reg_wr(`E1OH_OFS_CTRL_B, 8'h77);
    test_ecount();
    wait_bit(8720);
    test_insert();
    test_alarm();
    test_flags();
    summarize();
  end
endmodule : e1_overhead_receive_insert_test
`default_nettype wire

// ==== e1oh_cfg.svh ====
// e1oh_cfg.svh: offsets, field positions, reset values and frame positions of the overhead block
// assumes inclusion by the design file and the test bench; holds definitions, no logic
`ifndef E1OH_CFG_SVH
`define E1OH_CFG_SVH
`define E1OH_OFS_CTRL_A     8'hB0
`define E1OH_OFS_CTRL_B     8'hB1
`define E1OH_OFS_BUF_B      8'hB2
`define E1OH_OFS_BUF_A      8'hB4
`define E1OH_OFS_E_CNT      8'h83
`define E1OH_OFS_CRC_CNT    8'h84
`define E1OH_OFS_CODE       8'h85
`define E1OH_OFS_MON0       8'h86
`define E1OH_RST_REG        8'h00
`define E1OH_A_SA4          0
`define E1OH_A_SA5          1
`define E1OH_A_SA6          2
`define E1OH_A_SA7          4
`define E1OH_A_SA8          5
`define E1OH_A_EMODE        7:6
`define E1OH_B_EN           0
`define E1OH_B_SYNCDIS      1
`define E1OH_B_CRCSRC       3:2
`define E1OH_B_AMODE        4
`define E1OH_B_AIS          5
`define E1OH_B_ECLR         6
`define E1OH_B_CRCCLR       7
`define E1OH_BB_SA4         0
`define E1OH_BB_SA7         1
`define E1OH_BB_SA8         2
`define E1OH_BB_MASK_A      4
`define E1OH_BB_MASK_SA5    5
`define E1OH_BB_MASK_SA6    6
`define E1OH_BA_E1          0
`define E1OH_BA_E2          1
`define E1OH_BA_A           2
`define E1OH_BA_SA5         3
`define E1OH_FR_E1          4'hD
`define E1OH_FR_E2          4'hF
`define E1OH_FR_MFAS_LAST   4'hB
`define E1OH_FR_AFTER_LOCK  4'hC
`define E1OH_MFAS_PAT       6'h0B
`define E1OH_CODE_RUN       3'h7
`endif

// ==== e1oh_framer_model.sv ====
// e1oh_framer_model.sv: behavioural pcm framer sending a serial e1 stream
// assumes clk_sys at 20 MHz; one link bit is 8 system cycles, pins move on clk_sys falling edges
`timescale 1ns/1ps
`default_nettype none

module e1oh_framer_model (
  input  wire logic clk_sys,
  input  wire logic go,
  output logic      pcm_link_clk,
  output logic      hdsl_rx_data,
  output logic      receive_multiframe_sync_in,
  output int        bit_no
);
  int ph;

  // mfas 001011 in odd frames 1..11, rest of odd-frame overhead 0 so inserted ones stand out
  function automatic logic src_bit(input int n);
    int f;
    f = (n >> 8) % 16;
    if ((n >> 3) % 32 != 0) return ^(n & 32'h000009B3);
    if (f % 2 == 0) return n[0] ^ n[9];
    if (n % 8 != 0 || f > 11) return 1'b0;
    return (f == 5 || f == 9 || f == 11);
  endfunction : src_bit

  initial begin
    pcm_link_clk = 1'b0;
    hdsl_rx_data = 1'b0;
    receive_multiframe_sync_in = 1'b0;
    bit_no = 0;
    ph = 0;
  end

  // pcm clock runs free; data and sync change half a bit ahead of the rising edge
  always @(negedge clk_sys) begin
    if (go) begin
      if (ph == 0) begin
        pcm_link_clk = 1'b0;
        hdsl_rx_data = src_bit(bit_no);
        receive_multiframe_sync_in = (bit_no % 4096 == 0);
      end
      if (ph == 4) pcm_link_clk = 1'b1;
      if (ph == 7) bit_no = bit_no + 1;
      ph = (ph + 1) % 8;
    end
  end
endmodule : e1oh_framer_model
`default_nettype wire

// ==== e1oh_pkg.sv ====
// e1oh_pkg.sv: types of the overhead block
// assumes nothing of its surroundings
package e1oh_pkg;
  typedef enum logic [1:0] {SYNC_SYNC_SEARCH_STATE = 2'b01, SYNC_LOCK = 2'b10} e1oh_sync_e;
  typedef enum logic [1:0] {CRC_PASS = 2'h0, CRC_ONES = 2'h1, CRC_CALC = 2'h2, CRC_BAD = 2'h3} e1oh_crc_e;
  typedef enum logic [1:0] {EB_PASS = 2'h0, EB_BUF = 2'h1, EB_AUTO = 2'h2, EB_BAD = 2'h3} e1oh_ebit_e;
endpackage : e1oh_pkg

// ==== e1oh_top.sv ====
// e1oh_top.sv: e1 overhead insertion toward the pcm side, multiframe sync, crc and code detection
// assumes mpu strobes on clk_sys; link clock, data and sync pins are asynchronous
// Functional notes
// - auto E-bit: 0 after CRC fail, else 1
// - settings apply at next multiframe start only
// - enable bit switches overhead insertion, alarm fill, counters and code detection; sync and CRC fail flags run regardless
// - sync enabled: sync_search_state, sync input marks frames
// - sync disabled: sync input marks multiframes
// - CRC counter held clear while clear bit set
// - buffer bit used only when mode selects
// - code detected after 7 unchanged multiframes
// - per-field masks qualify code detection
// - buffer b low bits feed Sa4 Sa7 Sa8
// - buffer a used in odd frames only
// - buffered E1 goes into frame 13
// - buffered E2 goes into frame 15
// - buffered A-bit into every odd frame
// - Sa6 bits into frame pairs 1/9..7/15
// - E counter wraps at 255, own clear
// - spare mode 0 passes, 1 inserts buffer
`timescale 1ns/1ps
`default_nettype none
`include "e1oh_cfg.svh"

module e1oh_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;

  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : e1oh_fifo

module e1oh_top (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [7:0] mpu_addr,
  input  wire logic [7:0] mpu_wdata,
  input  wire logic       mpu_wr,
  input  wire logic       mpu_rd,
  output logic      [7:0] mpu_rdata,
  input  wire logic       pcm_link_clk,
  input  wire logic       hdsl_rx_data,
  input  wire logic       receive_multiframe_sync_in,
  output logic            pcm_tx_data,
  output logic            multiframe_locked,
  output logic            inband_code_detect,
  output logic            stream_overflow
);
  logic [1:0]  clk_s_q;
  logic [1:0]  dat_s_q;
  logic [1:0]  syn_s_q;
  logic        clk_d_q;
  logic        rise;
  logic        fall;
  logic        rx_bit;
  logic        sync_s;
  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_b_q;
  logic [7:0]  buf_b_q;
  logic [7:0]  buf_a_q;
  logic [7:0]  act_a_q;
  logic [7:0]  act_b_q;
  logic [7:0]  act_bb_q;
  logic [7:0]  act_ba_q;
  logic [2:0]  bit_q;
  logic [4:0]  slot_q;
  logic [3:0]  frame_q;
  logic [2:0]  cur_bit;
  logic [4:0]  cur_slot;
  logic [3:0]  cur_frame;
  logic        mf_mark;
  logic        fr_mark;
  logic        frame_end;
  logic        mf_end;
  logic        smf_end;
  logic        aligned;
  logic        oh_slot;
  logic        c_pos;
  logic [11:0] hist_q;
  logic        mfas_ok;
  logic        lock_hit;
  e1oh_pkg::e1oh_sync_e state_q;
  logic [3:0]  crc_rx_run_q;
  logic [3:0]  crc_rx_q;
  logic [3:0]  crc_tx_run_q;
  logic [3:0]  crc_tx_q;
  logic [3:0]  c_rx_q;
  logic [1:0]  fail_q;
  logic        mismatch;
  logic [7:0]  crc_cnt_q;
  logic [7:0]  e_cnt_q;
  logic        ob;
  logic        ebit;
  logic        pend_q;
  logic        pend_bit_q;
  logic        ovf_q;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_data;
  logic        ib_a_q;
  logic        ib_sa5_q;
  logic [3:0]  ib_sa6_q;
  logic [5:0]  ib_prev_q;
  logic [5:0]  ib_new;
  logic        ib_same;
  logic [2:0]  ib_cnt_q;
  logic        det_q;
  logic [7:0]  code_q;
  logic        tx_q;
  logic [7:0]  rdata_q;

  function automatic logic [3:0] crc4_step(input logic [3:0] c, input logic d);
    logic fb;
    fb = c[3] ^ d;
    return {c[2:0], 1'b0} ^ {2'h0, fb, fb};
  endfunction : crc4_step

  // link pins pass two flops; edges are found on the second stage only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_s_q <= 2'h0;
      dat_s_q <= 2'h0;
      syn_s_q <= 2'h0;
      clk_d_q <= 1'b0;
    end else begin
      clk_s_q <= {clk_s_q[0], pcm_link_clk};
      dat_s_q <= {dat_s_q[0], hdsl_rx_data};
      syn_s_q <= {syn_s_q[0], receive_multiframe_sync_in};
      clk_d_q <= clk_s_q[1];
    end
  end
  assign rise   = clk_s_q[1] & ~clk_d_q;
  assign fall   = ~clk_s_q[1] & clk_d_q;
  assign rx_bit = dat_s_q[1];
  assign sync_s = syn_s_q[1];

  // software copies; readback always shows these, not the active set
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_q <= `E1OH_RST_REG;
      ctrl_b_q <= `E1OH_RST_REG;
      buf_b_q  <= `E1OH_RST_REG;
      buf_a_q  <= `E1OH_RST_REG;
    end else if (mpu_wr) begin
      case (mpu_addr)
        `E1OH_OFS_CTRL_A: ctrl_a_q <= mpu_wdata;
        `E1OH_OFS_CTRL_B: ctrl_b_q <= mpu_wdata;
        `E1OH_OFS_BUF_B:  buf_b_q  <= mpu_wdata;
        `E1OH_OFS_BUF_A:  buf_a_q  <= mpu_wdata;
        default: ;
      endcase
    end
  end

  // a write landing in the boundary cycle waits one more multiframe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      act_a_q  <= `E1OH_RST_REG;
      act_b_q  <= `E1OH_RST_REG;
      act_bb_q <= `E1OH_RST_REG;
      act_ba_q <= `E1OH_RST_REG;
    end else if (mf_end) begin
      act_a_q  <= ctrl_a_q;
      act_b_q  <= ctrl_b_q;
      act_bb_q <= buf_b_q;
      act_ba_q <= buf_a_q;
    end
  end

  assign mf_mark   = act_b_q[`E1OH_B_SYNCDIS] & sync_s;
  assign fr_mark   = ~act_b_q[`E1OH_B_SYNCDIS] & sync_s;
  assign cur_bit   = (mf_mark || fr_mark) ? 3'h0 : bit_q;
  assign cur_slot  = (mf_mark || fr_mark) ? 5'h00 : slot_q;
  assign cur_frame = mf_mark ? 4'h0 : frame_q;
  assign frame_end = rise & (cur_slot == 5'h1F) & (cur_bit == 3'h7);
  assign mf_end    = frame_end & (cur_frame == 4'hF);
  assign smf_end   = frame_end & (cur_frame[2:0] == 3'h7);
  assign aligned   = act_b_q[`E1OH_B_SYNCDIS] | (state_q == e1oh_pkg::SYNC_LOCK);
  assign oh_slot   = act_b_q[`E1OH_B_EN] & aligned & (cur_slot == 5'h00);
  assign c_pos     = (cur_slot == 5'h00) & ~cur_frame[0] & (cur_bit == 3'h0);
  assign mfas_ok   = {hist_q[10], hist_q[8], hist_q[6], hist_q[4], hist_q[2], hist_q[0]} == `E1OH_MFAS_PAT;
  assign lock_hit  = frame_end & ~act_b_q[`E1OH_B_SYNCDIS] & (state_q == e1oh_pkg::SYNC_SYNC_SEARCH_STATE) & mfas_ok;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_q   <= 3'h0;
      slot_q  <= 5'h00;
      frame_q <= 4'h0;
    end else if (rise) begin
      bit_q  <= cur_bit + 3'h1;
      slot_q <= (cur_bit == 3'h7) ? cur_slot + 5'h01 : cur_slot;
      if (lock_hit) begin
        frame_q <= `E1OH_FR_AFTER_LOCK;
      end else begin
        frame_q <= frame_end ? cur_frame + 4'h1 : cur_frame;
      end
    end
  end

  // bit 1 of slot 0 per frame; alignment word sits in the odd frames
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hist_q <= 12'h000;
    end else if (rise && cur_slot == 5'h00 && cur_bit == 3'h0) begin
      hist_q <= {hist_q[10:0], rx_bit};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= e1oh_pkg::SYNC_SYNC_SEARCH_STATE;
    end else if (act_b_q[`E1OH_B_SYNCDIS]) begin
      state_q <= e1oh_pkg::SYNC_SYNC_SEARCH_STATE;
    end else if (lock_hit) begin
      state_q <= e1oh_pkg::SYNC_LOCK;
    end else if (frame_end && state_q == e1oh_pkg::SYNC_LOCK && cur_frame == `E1OH_FR_MFAS_LAST && !mfas_ok) begin
      state_q <= e1oh_pkg::SYNC_SYNC_SEARCH_STATE;
    end
  end
  assign multiframe_locked = (state_q == e1oh_pkg::SYNC_LOCK);

  // check bits are zeroed in the sum, as the far end computes them
  assign mismatch = (c_rx_q != crc_rx_q);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      crc_rx_run_q <= 4'h0;
      crc_rx_q     <= 4'h0;
      crc_tx_run_q <= 4'h0;
      crc_tx_q     <= 4'h0;
      c_rx_q       <= 4'h0;
      fail_q       <= 2'h0;
    end else if (rise && aligned) begin
      crc_rx_run_q <= smf_end ? 4'h0 : crc4_step(crc_rx_run_q, rx_bit & ~c_pos);
      crc_tx_run_q <= smf_end ? 4'h0 : crc4_step(crc_tx_run_q, ob & ~c_pos);
      if (c_pos) begin
        c_rx_q[~cur_frame[2:1]] <= rx_bit;
      end
      if (smf_end) begin
        crc_rx_q <= crc4_step(crc_rx_run_q, rx_bit);
        crc_tx_q <= crc4_step(crc_tx_run_q, ob);
        fail_q[cur_frame[3]] <= mismatch;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      crc_cnt_q <= 8'h00;
    end else if (act_b_q[`E1OH_B_CRCCLR]) begin
      crc_cnt_q <= 8'h00;
    end else if (smf_end && aligned && act_b_q[`E1OH_B_EN] && mismatch) begin
      crc_cnt_q <= crc_cnt_q + 8'h01;
    end
  end

  // 8-bit counter wraps from 255 to 0 by itself
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      e_cnt_q <= 8'h00;
    end else if (act_b_q[`E1OH_B_ECLR]) begin
      e_cnt_q <= 8'h00;
    end else if (rise && oh_slot && cur_bit == 3'h0 && (cur_frame == `E1OH_FR_E1 || cur_frame == `E1OH_FR_E2) && !rx_bit) begin
      e_cnt_q <= e_cnt_q + 8'h01;
    end
  end

  always_comb begin
    ebit = rx_bit;
    if (cur_frame == `E1OH_FR_E1 || cur_frame == `E1OH_FR_E2) begin
      unique case (e1oh_pkg::e1oh_ebit_e'(act_a_q[`E1OH_A_EMODE]))
        e1oh_pkg::EB_BUF:  ebit = cur_frame[1] ? act_ba_q[`E1OH_BA_E2] : act_ba_q[`E1OH_BA_E1];
        e1oh_pkg::EB_AUTO: ebit = ~fail_q[cur_frame[1]];
        e1oh_pkg::EB_PASS: ebit = rx_bit;
        e1oh_pkg::EB_BAD:  ebit = rx_bit;
      endcase
    end
  end

  // processing off leaves the stream untouched, alarm fill included
  always_comb begin
    ob = rx_bit;
    if (act_b_q[`E1OH_B_EN] && cur_slot != 5'h00 && act_b_q[`E1OH_B_AIS]) begin
      ob = 1'b1;
    end else if (oh_slot && cur_frame[0]) begin
      unique case (cur_bit)
        3'h0: ob = ebit;
        3'h1: ob = rx_bit;
        3'h2: ob = act_b_q[`E1OH_B_AMODE] ? act_ba_q[`E1OH_BA_A] : rx_bit;
        3'h3: ob = act_a_q[`E1OH_A_SA4] ? act_bb_q[`E1OH_BB_SA4] : rx_bit;
        3'h4: ob = act_a_q[`E1OH_A_SA5] ? act_ba_q[`E1OH_BA_SA5] : rx_bit;
        3'h5: ob = act_a_q[`E1OH_A_SA6] ? act_ba_q[{1'b1, cur_frame[2:1]}] : rx_bit;
        3'h6: ob = act_a_q[`E1OH_A_SA7] ? act_bb_q[`E1OH_BB_SA7] : rx_bit;
        3'h7: ob = act_a_q[`E1OH_A_SA8] ? act_bb_q[`E1OH_BB_SA8] : rx_bit;
      endcase
    end else if (oh_slot && c_pos) begin
      unique case (e1oh_pkg::e1oh_crc_e'(act_b_q[`E1OH_B_CRCSRC]))
        e1oh_pkg::CRC_ONES: ob = 1'b1;
        e1oh_pkg::CRC_CALC: ob = crc_tx_q[~cur_frame[2:1]];
        e1oh_pkg::CRC_PASS: ob = rx_bit;
        e1oh_pkg::CRC_BAD:  ob = rx_bit;
      endcase
    end
  end

  // one-bit holding stage; a stalled fifo drops the held bit and flags it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pend_q     <= 1'b0;
      pend_bit_q <= 1'b0;
      ovf_q      <= 1'b0;
    end else begin
      if (rise) begin
        pend_q     <= 1'b1;
        pend_bit_q <= ob;
      end else if (fifo_in_ready) begin
        pend_q <= 1'b0;
      end
      if (rise && pend_q && !fifo_in_ready) begin
        ovf_q <= 1'b1;
      end else if (mpu_rd && mpu_addr == `E1OH_OFS_MON0) begin
        ovf_q <= 1'b0;
      end
    end
  end
  assign stream_overflow = ovf_q;

  e1oh_fifo #(
    .WIDTH (1),
    .DEPTH (16)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (pend_q),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_bit_q),
    .out_valid (fifo_out_valid),
    .out_ready (fall),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= 1'b0;
    end else if (fall && fifo_out_valid) begin
      tx_q <= fifo_out_data;
    end
  end
  assign pcm_tx_data = tx_q;

  assign ib_new  = {ib_sa6_q, ib_sa5_q, ib_a_q};
  assign ib_same = (!act_bb_q[`E1OH_BB_MASK_A] || ib_new[0] == ib_prev_q[0]) &&
                   (!act_bb_q[`E1OH_BB_MASK_SA5] || ib_new[1] == ib_prev_q[1]) &&
                   (!act_bb_q[`E1OH_BB_MASK_SA6] || ib_new[5:2] == ib_prev_q[5:2]);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ib_a_q    <= 1'b0;
      ib_sa5_q  <= 1'b0;
      ib_sa6_q  <= 4'h0;
      ib_prev_q <= 6'h00;
      ib_cnt_q  <= 3'h0;
      det_q     <= 1'b0;
      code_q    <= 8'h00;
    end else begin
      if (rise && oh_slot && cur_frame[0]) begin
        if (cur_bit == 3'h2 && cur_frame == 4'hF) begin
          ib_a_q <= rx_bit;
        end
        if (cur_bit == 3'h4 && cur_frame == 4'hF) begin
          ib_sa5_q <= rx_bit;
        end
        if (cur_bit == 3'h5 && !cur_frame[3]) begin
          ib_sa6_q[cur_frame[2:1]] <= rx_bit;
        end
      end
      // the boundary lies in slot 31, so it cannot sit under the slot 0 gate
      if (mf_end && act_b_q[`E1OH_B_EN] && aligned) begin
        ib_prev_q <= ib_new;
        ib_cnt_q  <= !ib_same ? 3'h0 : (ib_cnt_q == `E1OH_CODE_RUN) ? ib_cnt_q : ib_cnt_q + 3'h1;
        det_q     <= ib_same && ib_cnt_q >= (`E1OH_CODE_RUN - 3'h1);
        if (ib_same && ib_cnt_q >= (`E1OH_CODE_RUN - 3'h1)) begin
          code_q <= {ib_new[5:2], 2'h0, ib_new[1:0]};
        end
      end
    end
  end
  assign inband_code_detect = det_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (mpu_rd) begin
      case (mpu_addr)
        `E1OH_OFS_CTRL_A:  rdata_q <= ctrl_a_q;
        `E1OH_OFS_CTRL_B:  rdata_q <= ctrl_b_q;
        `E1OH_OFS_BUF_B:   rdata_q <= buf_b_q;
        `E1OH_OFS_BUF_A:   rdata_q <= buf_a_q;
        `E1OH_OFS_E_CNT:   rdata_q <= e_cnt_q;
        `E1OH_OFS_CRC_CNT: rdata_q <= crc_cnt_q;
        `E1OH_OFS_CODE:    rdata_q <= code_q;
        `E1OH_OFS_MON0:    rdata_q <= {multiframe_locked, 3'h0, ovf_q, 1'b0, fail_q[1], fail_q[0]};
        default:           rdata_q <= 8'h00;
      endcase
    end
  end
  assign mpu_rdata = rdata_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_boundary;
    mf_end;
  endsequence
  property p_apply_at_boundary;
    !$stable(act_b_q) || !$stable(act_ba_q) |-> $past(mf_end);
  endproperty
  a_apply_at_boundary: assert property (p_apply_at_boundary) else $error("setting applied mid-multiframe");
  property p_write_held;
    s_boundary ##0 !mpu_wr ##1 (!mf_end && !mpu_wr) [*2] |-> act_b_q == ctrl_b_q;
  endproperty
  a_write_held: assert property (p_write_held) else $error("active copy differs after boundary");
  property p_ebit_auto;
    rise && oh_slot && cur_bit == 3'h0 && cur_frame == `E1OH_FR_E1 && act_a_q[7:6] == 2'h2 |-> ob == !fail_q[0];
  endproperty
  a_ebit_auto: assert property (p_ebit_auto) else $error("auto e-bit wrong");
  property p_disabled_pass;
    rise && !act_b_q[`E1OH_B_EN] |-> ob == rx_bit ##1 pend_bit_q == $past(rx_bit);
  endproperty
  a_disabled_pass: assert property (p_disabled_pass) else $error("stream altered while disabled");
  property p_sync_search_state_on_enable;
    $fell(act_b_q[`E1OH_B_SYNCDIS]) |-> state_q == e1oh_pkg::SYNC_SYNC_SEARCH_STATE;
  endproperty
  a_sync_search_state_on_enable: assert property (p_sync_search_state_on_enable) else $error("sync not hunting");
  property p_mf_marker;
    rise && act_b_q[`E1OH_B_SYNCDIS] && sync_s |=> frame_q == 4'h0 && slot_q == 5'h00 && bit_q == 3'h1;
  endproperty
  a_mf_marker: assert property (p_mf_marker) else $error("marker did not restart multiframe");
  property p_crc_clear;
    act_b_q[`E1OH_B_CRCCLR] [*2] |-> crc_cnt_q == 8'h00;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc counter not held clear");
  property p_e_clear;
    act_b_q[`E1OH_B_ECLR] [*2] |-> e_cnt_q == 8'h00;
  endproperty
  a_e_clear: assert property (p_e_clear) else $error("e counter not held clear");
  property p_sa4_ignored;
    rise && oh_slot && cur_frame[0] && cur_bit == 3'h3 && !act_a_q[`E1OH_A_SA4] |-> ob == rx_bit;
  endproperty
  a_sa4_ignored: assert property (p_sa4_ignored) else $error("buffer used while mode clear");
  property p_sa6_pair;
    rise && oh_slot && cur_frame[0] && cur_bit == 3'h5 && act_a_q[`E1OH_A_SA6] |->
      ob == ((cur_frame[2:1] == 2'h0) ? act_ba_q[4] : (cur_frame[2:1] == 2'h1) ? act_ba_q[5] :
             (cur_frame[2:1] == 2'h2) ? act_ba_q[6] : act_ba_q[7]);
  endproperty
  a_sa6_pair: assert property (p_sa6_pair) else $error("sa6 bit in wrong frame");
  property p_code_run;
    $rose(det_q) |-> ib_cnt_q == `E1OH_CODE_RUN && $past(mf_end);
  endproperty
  a_code_run: assert property (p_code_run) else $error("code flagged too early");
  property p_ais_fill;
    rise && act_b_q[`E1OH_B_EN] && act_b_q[`E1OH_B_AIS] && cur_slot != 5'h00 |-> ob;
  endproperty
  a_ais_fill: assert property (p_ais_fill) else $error("alarm fill missing");
endmodule : e1oh_top
`default_nettype wire
